// file: rtl/ddr_port_consts.svh
// Constants for the two-word burst SRAM port
`ifndef DDR_PORT_CONSTS_SVH
`define DDR_PORT_CONSTS_SVH
// Narrow part: 2 arrays of 512K x 18
`define DDR_ADDR_W      19
`define DDR_DATA_W      18
`define DDR_LANE_W      9
// Read pipe taps: word 0 launch index (PLL on = 2.5 cycles, PLL off = 1 cycle)
`define DDR_RD_TAP_PLL  3
`define DDR_RD_TAP_OFF  0
`define DDR_RD_PIPE_W   5
// Write capture: word 0 one K cycle after the load, word 1 on the following K# edge
`define DDR_WR_TAP0     2
`define DDR_WR_TAP1     3
// Floating termination select defaults to the high range
`define DDR_TERM_RESET  1'h1
`endif

// file: rtl/ddr_port_pkg.sv
// Types shared by the two-word burst SRAM port
package ddr_port_pkg;
   typedef enum logic {LAT_PLL, LAT_DIRECT} lat_mode_e;
   typedef struct packed {
      logic load_strobe_n;
      logic rd_wr;
      logic pll_disable_n;
      logic term_range_sel;
   } pin_ctl_s;
endpackage : ddr_port_pkg

// file: rtl/ddr_array.sv
// One internal array with per-lane write enables and registered read data
`timescale 1ns/10ps
`default_nettype none
module ddr_array #(
   parameter int AW    = 19,
   parameter int DW    = 18,
   parameter int LW    = 9,
   parameter int LANES = DW / LW
) (
   input  wire logic             i_clk,
   input  wire logic             i_we,
   input  wire logic [LANES-1:0] i_lane_en,
   input  wire logic [AW-1:0]    i_waddr,
   input  wire logic [DW-1:0]    i_wdata,
   input  wire logic             i_re,
   input  wire logic [AW-1:0]    i_raddr,
   output var  logic [DW-1:0]    o_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_clk) begin
      if (i_we) begin
         for (int i = 0; i < LANES; i++) begin
            // Disabled lanes keep their stored byte
            if (i_lane_en[i]) begin
               mem[i_waddr][i*LW +: LW] <= i_wdata[i*LW +: LW];
            end
         end
      end
      if (i_re) begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule : ddr_array
`default_nettype wire

// file: rtl/ddr_burst2_sram_port.sv
// Pin-level two-word burst double-data-rate SRAM port
// Functional notes
// - Write word 0 captured on K edge, word 1 on following K# edge.
// - Read words launched one on K edge, the other on K# edge.
// - Data outputs released whenever no read data is being driven.
// - Every access moves exactly two words per loaded address.
// - Shared address sampled at the K edge of the load.
// - Two internal arrays, each address holding a two-word pair.
// - Read/write select high means read, low write, sampled with load.
// - Each active-low byte select gates one 9-bit data lane.
// - Byte selects sampled on the same edge as their data word.
// - Inactive byte select leaves that stored byte unchanged.
// - Read-valid high while read data is driven, aligned to echo clocks.
// - Termination range latched at power-up; high by default.
// - Accesses start only on K edges; K# edges carry second words, except PLL-on reads, whose first word is on K#.
// - K# edges capture write data and launch read data.
// - Free-running echo clocks follow the K phase.
// - PLL disabled gives single-cycle read latency mode.
`timescale 1ns/10ps
`default_nettype none
`include "ddr_port_consts.svh"
module ddr_burst2_sram_port
   import ddr_port_pkg::*;
#(
   parameter int ADDR_W = `DDR_ADDR_W,
   parameter int DATA_W = `DDR_DATA_W,
   parameter int LANES  = DATA_W / `DDR_LANE_W
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic              i_load_strobe_n,
   input  wire logic              i_rd_wr,
   input  wire logic [LANES-1:0]  i_byte_write_sel_n,
   input  wire logic [DATA_W-1:0] i_dq,
   output var  logic [DATA_W-1:0] o_dq,
   output var  logic              o_dq_oe,
   output var  logic              o_read_valid,
   output var  logic              o_echo_clk,
   output var  logic              o_echo_clk_n,
   input  wire logic              i_term_range_sel,
   input  wire logic              i_pll_disable_n,
   output var  logic              o_term_range_high
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers, no reset so they are full when reset lifts
   pin_ctl_s          ctl_s1, ctl_s2;
   logic [ADDR_W-1:0] addr_s1, addr_s2;
   logic [LANES-1:0]  bws_s1, bws_s2;
   logic [DATA_W-1:0] dq_s1, dq_s2;

   always_ff @(posedge i_clk) begin
      ctl_s1  <= '{i_load_strobe_n, i_rd_wr, i_pll_disable_n, i_term_range_sel};
      ctl_s2  <= ctl_s1;
      addr_s1 <= i_addr;
      addr_s2 <= addr_s1;
      bws_s1  <= i_byte_write_sel_n;
      bws_s2  <= bws_s1;
      dq_s1   <= i_dq;
      dq_s2   <= dq_s1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Phase divider, access pipes, output stage
   logic                      ph, next_ph;
   logic                      next_echo;
   logic [`DDR_RD_PIPE_W-1:0] rd_sh, next_rd_sh;
   // Write taps: word 0 in the K phase one K cycle after the load, word 1 in the K# after it
   logic [`DDR_WR_TAP1:1]     wr_sh, next_wr_sh;
   logic [ADDR_W-1:0]         wr_addr, next_wr_addr;
   logic [DATA_W-1:0]         next_dq;
   logic                      next_oe;
   logic                      term_done, next_term_done, next_term_high;
   logic                      acc_rd, acc_wr, launch0, launch1;
   lat_mode_e                 mode;
   logic [DATA_W-1:0]         rdata0, rdata1;
   logic [LANES-1:0]          lane_en;

   always_comb begin
      mode      = ctl_s2.pll_disable_n ? LAT_PLL : LAT_DIRECT;
      // Only a K-phase sample starts an access; no new load is expected
      // on the next two K edges, so pipes never need to hold two reads.
      acc_rd    = !ctl_s2.load_strobe_n && !ph && ctl_s2.rd_wr;
      acc_wr    = !ctl_s2.load_strobe_n && !ph && !ctl_s2.rd_wr;
      launch0   = 1'b0;
      launch1   = 1'b0;
      // Both words were fetched at the load, so the pipe only times their launch
      case (mode)
         LAT_PLL: begin
            launch0 = rd_sh[`DDR_RD_TAP_PLL];
            launch1 = rd_sh[`DDR_RD_TAP_PLL + 1];
         end
         LAT_DIRECT: begin
            launch0 = rd_sh[`DDR_RD_TAP_OFF];
            launch1 = rd_sh[`DDR_RD_TAP_OFF + 1];
         end
         default: begin
            launch0 = 1'b0;
            launch1 = 1'b0;
         end
      endcase
      next_ph        = ~ph;
      next_echo      = !next_ph;
      next_rd_sh     = {rd_sh[`DDR_RD_PIPE_W-2:0], acc_rd};
      next_wr_sh     = {wr_sh[`DDR_WR_TAP1-1:1], acc_wr};
      next_wr_addr   = acc_wr ? addr_s2 : wr_addr;
      next_oe        = launch0 || launch1;
      next_dq        = launch0 ? rdata0 : (launch1 ? rdata1 : '0);
      next_term_done = 1'b1;
      next_term_high = term_done ? o_term_range_high : ctl_s2.term_range_sel;
      lane_en        = ~bws_s2;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ph                <= 1'b0;
         o_echo_clk        <= 1'b1;
         o_echo_clk_n      <= 1'b0;
         rd_sh             <= '0;
         wr_sh             <= '0;
         wr_addr           <= '0;
         o_dq              <= '0;
         o_dq_oe           <= 1'b0;
         o_read_valid      <= 1'b0;
         term_done         <= 1'b0;
         o_term_range_high <= `DDR_TERM_RESET;
      end else begin
         ph                <= next_ph;
         o_echo_clk        <= next_echo;
         o_echo_clk_n      <= !next_echo;
         rd_sh             <= next_rd_sh;
         wr_sh             <= next_wr_sh;
         wr_addr           <= next_wr_addr;
         o_dq              <= next_dq;
         o_dq_oe           <= next_oe;
         o_read_valid      <= next_oe;
         term_done         <= next_term_done;
         o_term_range_high <= next_term_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Two arrays: array 0 holds the first word of each pair, array 1 the second
   ddr_array #(.AW(ADDR_W), .DW(DATA_W), .LW(`DDR_LANE_W), .LANES(LANES)) u_word0 (
      .i_clk     (i_clk),
      .i_we      (wr_sh[`DDR_WR_TAP0]),
      .i_lane_en (lane_en),
      .i_waddr   (wr_addr),
      .i_wdata   (dq_s2),
      .i_re      (acc_rd),
      .i_raddr   (addr_s2),
      .o_rdata   (rdata0)
   );

   ddr_array #(.AW(ADDR_W), .DW(DATA_W), .LW(`DDR_LANE_W), .LANES(LANES)) u_word1 (
      .i_clk     (i_clk),
      .i_we      (wr_sh[`DDR_WR_TAP1]),
      .i_lane_en (lane_en),
      .i_waddr   (wr_addr),
      .i_wdata   (dq_s2),
      .i_re      (acc_rd),
      .i_raddr   (addr_s2),
      .o_rdata   (rdata1)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions and covers
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   oe_only_valid_a: assert property ((o_dq_oe == o_read_valid)
      && (o_dq_oe || o_dq == '0))
      else $error("data driven outside a read burst");
   idle_release_a: assert property ((rd_sh == '0) |=> !o_dq_oe)
      else $error("data driven with no read in flight");

   pll_latency_a: assert property ((acc_rd && mode == LAT_PLL)
      |-> ##5 (o_read_valid && ph) ##1 (o_read_valid && !ph) ##1 !o_read_valid)
      else $error("PLL read burst not at 2.5 cycles");
   direct_latency_a: assert property ((acc_rd && mode == LAT_DIRECT)
      |-> ##2 (o_read_valid && !ph) ##1 o_read_valid ##1 !o_read_valid)
      else $error("PLL-off read burst not at 1 cycle");
   pair_len_a: assert property ($rose(o_read_valid)
      |=> o_read_valid ##1 !o_read_valid)
      else $error("read burst not two words long");

   // The phase restarts at reset release, so the first edge after it is skipped
   echo_free_run_a: assert property (!$past(i_rst)
      |-> (o_echo_clk != $past(o_echo_clk))
          && (o_echo_clk_n == !o_echo_clk) && (o_echo_clk == !ph))
      else $error("echo clocks not following K phase");
   start_on_k_a: assert property ((rd_sh[0] || wr_sh[1]) |-> $past(ph) == 1'b0)
      else $error("access started on K# phase");

   write_phase_a: assert property (acc_wr
      |=> ##1 (wr_sh[`DDR_WR_TAP0] && !ph) ##1 (wr_sh[`DDR_WR_TAP1] && ph))
      else $error("write words not on K then K#");
   wr_addr_a: assert property (acc_wr |=> wr_addr == $past(addr_s2))
      else $error("write address not taken with the load");
   read_pair_a: assert property (launch0 |=> o_dq == $past(rdata0) ##1 o_dq == rdata1)
      else $error("read words out of order");

   // Peeks at array 0: a masked upper byte (lane 1) must keep its old value across the word 0 write
   mask_lane_a: assert property (wr_sh[`DDR_WR_TAP0] && bws_s2[1]
      |=> u_word0.mem[wr_addr][`DDR_LANE_W +: `DDR_LANE_W]
          == $past(u_word0.mem[wr_addr][`DDR_LANE_W +: `DDR_LANE_W]))
      else $error("masked byte overwritten");
   term_hold_a: assert property (term_done |=> $stable(o_term_range_high))
      else $error("termination range changed after power-up");
   term_capture_a: assert property ($rose(term_done)
      |-> o_term_range_high == $past(ctl_s2.term_range_sel))
      else $error("termination range not taken after reset");

   // Main scenarios: both read latencies, masked writes, a read after a write
   read_pll_c:    cover property (acc_rd && mode == LAT_PLL ##5 o_read_valid);
   read_direct_c: cover property (acc_rd && mode == LAT_DIRECT ##2 o_read_valid);
   write_mask_c:  cover property (wr_sh[`DDR_WR_TAP0] && !(&lane_en));
   mask_pair_c:   cover property (wr_sh[`DDR_WR_TAP0] ##1 (wr_sh[`DDR_WR_TAP1] && !(&lane_en)));
   rd_after_wr_c: cover property (acc_wr ##2 acc_rd);
endmodule : ddr_burst2_sram_port
`default_nettype wire

// file: tb/ctl_model.sv
// Memory controller model that drives the burst SRAM port pins
`timescale 1ns/10ps
`default_nettype none
`include "ddr_port_consts.svh"
module ctl_model (
   input  wire logic                   i_clk,
   input  wire logic                   i_echo_clk,
   input  wire logic                   i_read_valid,
   input  wire logic [`DDR_DATA_W-1:0] i_q,
   output var  logic [`DDR_ADDR_W-1:0] o_addr,
   output var  logic                   o_load_strobe_n,
   output var  logic                   o_rd_wr,
   output var  logic [1:0]             o_byte_write_sel_n,
   output var  logic [`DDR_DATA_W-1:0] o_dq
);
   localparam int AW = `DDR_ADDR_W;
   localparam int DW = `DDR_DATA_W;
   int n_timeouts;
   initial begin
      n_timeouts = 0;
      o_addr = '0;
      o_load_strobe_n = 1'b1;
      o_rd_wr = 1'b0;
      o_byte_write_sel_n = 2'b11;
      o_dq = '0;
   end
   // Odd set puts the load in the wrong phase on purpose
   task automatic load(input logic [AW-1:0] a, input logic rd, input logic odd);
      int n;
      n = 0;
      @(posedge i_clk);
      while (i_echo_clk !== odd && n < 4) begin
         @(posedge i_clk);
         n++;
      end
      // A stuck echo clock counts against the run, and the load still goes ahead
      if (i_echo_clk !== odd) n_timeouts++;
      o_load_strobe_n <= 1'b0;
      o_addr <= a;
      o_rd_wr <= rd;
      @(posedge i_clk);
      o_load_strobe_n <= 1'b1;
      // Released lines show the inverse, never the old value
      o_addr <= ~a;
      o_rd_wr <= ~rd;
   endtask : load
   task automatic write(input logic [AW-1:0] a, input logic [DW-1:0] d0, d1,
                        input logic [1:0] m0, m1, input logic odd);
      load(a, 1'b0, odd);
      @(posedge i_clk);
      o_dq <= d0;
      o_byte_write_sel_n <= m0;
      @(posedge i_clk);
      o_dq <= d1;
      o_byte_write_sel_n <= m1;
      @(posedge i_clk);
      o_dq <= ~d1;
      o_byte_write_sel_n <= 2'b11;
   endtask : write
   task automatic read(input logic [AW-1:0] a, output logic [DW-1:0] w0, w1, output int k);
      load(a, 1'b1, 1'b0);
      k = 1;
      while (i_read_valid !== 1'b1 && k < 12) begin
         @(posedge i_clk);
         k++;
      end
      w0 = i_q;
      @(posedge i_clk);
      w1 = i_q;
   endtask : read
endmodule : ctl_model
`default_nettype wire

// file: tb/ddr_burst2_sram_port_tb.sv
// Self-checking bench for the two-word burst SRAM port
`timescale 1ns/10ps
`default_nettype none
`include "ddr_port_consts.svh"
module ddr_burst2_sram_port_tb;
   localparam int AW = `DDR_ADDR_W;
   localparam int DW = `DDR_DATA_W;
   logic          i_clk, i_rst, ld_n, rw, oe, rv, ek, ek_n, term, pll_n, trh, pr, pe;
   logic [AW-1:0] addr;
   logic [1:0]    bws_n;
   logic [DW-1:0] dq_in, dq_out;
   int            n_errors, checked, run;
   ddr_burst2_sram_port i_ddr_burst2_sram_port (.i_clk(i_clk), .i_rst(i_rst),
      .i_addr(addr), .i_load_strobe_n(ld_n), .i_rd_wr(rw), .i_byte_write_sel_n(bws_n),
      .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(oe), .o_read_valid(rv), .o_echo_clk(ek),
      .o_echo_clk_n(ek_n), .i_term_range_sel(term), .i_pll_disable_n(pll_n),
      .o_term_range_high(trh));
   ctl_model i_ctl_model (.i_clk(i_clk), .i_echo_clk(ek), .i_read_valid(rv), .i_q(dq_out),
      .o_addr(addr), .o_load_strobe_n(ld_n), .o_rd_wr(rw), .o_byte_write_sel_n(bws_n),
      .o_dq(dq_in));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done;
      n_errors += i_ctl_model.n_timeouts;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e0, e1, input int lat);
      logic [DW-1:0] w0, w1;
      int            k;
      i_ctl_model.read(a, w0, w1, k);
      chk(w0, e0);
      chk(w1, e1);
      chk(DW'(k), DW'(lat));
      if (k >= 12) test_done();
   endtask : rd_chk
   // Termination select moves after release; the latched range must not follow
   task automatic t_reset(input logic t);
      term <= t;
      i_rst <= 1'b1;
      repeat (20) @(posedge i_clk);
      chk(trh, 1'b1);
      i_rst <= 1'b0;
      @(posedge i_clk);
      term <= ~t;
      repeat (4) @(posedge i_clk);
      chk(trh, t);
   endtask : t_reset
   task automatic t_burst;
      for (int i = 0; i < 2; i++) begin
         i_ctl_model.write(AW'(19'h0_0100 + i), DW'(18'h1_2340 + i), DW'(18'h2_abc0 + i),
                           2'b00, 2'b00, 1'b0);
      end
      rd_chk(19'h0_0101, 18'h1_2341, 18'h2_abc1, 8);
      rd_chk(19'h0_0100, 18'h1_2340, 18'h2_abc0, 8);
   endtask : t_burst
   task automatic t_mask;
      i_ctl_model.write(19'h5_0000, 18'h3_ffff, 18'h3_ffff, 2'b00, 2'b00, 1'b0);
      i_ctl_model.write(19'h5_0000, 18'h0_0000, 18'h0_0000, 2'b10, 2'b01, 1'b0);
      rd_chk(19'h5_0000, 18'h3_fe00, 18'h0_01ff, 8);
   endtask : t_mask
   task automatic t_phase;
      i_ctl_model.write(19'h0_0100, 18'h0_5555, 18'h0_aaaa, 2'b00, 2'b00, 1'b1);
      rd_chk(19'h0_0100, 18'h1_2340, 18'h2_abc0, 8);
   endtask : t_phase
   task automatic t_pll_off;
      pll_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd_chk(19'h5_0000, 18'h3_fe00, 18'h0_01ff, 5);
      pll_n <= 1'b1;
      repeat (4) @(posedge i_clk);
   endtask : t_pll_off
   // Pin watch each cycle; skipped right after reset where echo does not toggle
   always @(posedge i_clk) begin
      if (!i_rst && !pr) begin
         chk(ek, !pe);
         chk(ek_n, !ek);
         chk(oe, rv);
         if (!rv) chk(dq_out, '0);
         if (!rv && run != 0) chk(DW'(run), DW'(2));
      end
      run = rv ? run + 1 : 0;
      pr = i_rst;
      pe = ek;
   end
   initial begin
      n_errors = 0;
      checked = 0;
      run = 0;
      pr = 1'b1;
      pe = 1'b1;
      i_rst = 1'b1;
      term = 1'b1;
      pll_n = 1'b1;
      t_reset(1'b0);
      t_burst();
      t_mask();
      t_phase();
      t_pll_off();
      t_reset(1'b1);
      test_done();
   end
endmodule : ddr_burst2_sram_port_tb
`default_nettype wire
